// ### qhc_pkg.sv
// package: register indices, mode bits, status bits, error codes
package qhc_pkg;
    // ------------------------------------------------------------
    // register word indices
    // ------------------------------------------------------------
    localparam logic [3:0] IN_STATUS = 4'h0;
    localparam logic [3:0] IN_ERR_BASE = 4'h1;
    localparam logic [3:0] IN_CNT_BASE = 4'h5;
    localparam logic [3:0] IN_LAST = 4'h8;
    localparam logic [2:0] OUT_LAST = 3'h7;
    localparam int NUM_CH = 4;
    localparam int WORD_W = 16;
    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int ST_COMMS_LOSS = 15;
    localparam int ST_UNHEALTHY = 14;
    localparam int ST_EXCEED_LO = 8;
    localparam int ST_REACH_LO = 4;
    // ------------------------------------------------------------
    // mode word bit positions
    // ------------------------------------------------------------
    localparam int MD_UP = 6;
    localparam int MD_OUT_LOW = 5;
    localparam int MD_EN_HIGH = 4;
    localparam int MD_FALL = 3;
    localparam int MD_FAST = 2;
    localparam int MD_DIFF = 1;
    localparam logic [15:0] MODE_RESET = 16'h0040;
    localparam logic [15:0] TARGET_RESET = 16'h0000;
    // ------------------------------------------------------------
    // error codes
    // ------------------------------------------------------------
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_DIFF_FAST = 16'h0001;
    localparam logic [15:0] ERR_DIFF_REP = 16'h0002;
    localparam logic [15:0] ERR_FAST_CH = 16'h0003;
    localparam logic [15:0] ERR_MODE_CHG = 16'h0004;
    localparam logic [15:0] ERR_DIFF_CH = 16'h0005;
    localparam logic [15:0] ERR_TARGET = 16'h0006;
    // ------------------------------------------------------------
    // card identity and link watchdog
    // ------------------------------------------------------------
    localparam logic [7:0] CARD_ID = 8'h5A; // arbitrary value
    localparam int CLK_HZ = 10_000_000;
    localparam int LINK_TIMEOUT_US = 100;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * (CLK_HZ / 1_000_000);
endpackage

// ### qhc_cfg_if.sv
// interface: one channel's configuration toward its counter
`timescale 1ns/1ps
interface qhc_cfg_if;
    logic [15:0] mode; // mode word
    logic [15:0] target; // target count
    logic [15:0] count; // live count
    logic reached; // count equals target
    logic exceeded; // count beyond target
    logic gate_ok; // gate pin at its high level
    logic out_level; // counter output pin level
    modport ctl (output mode, target,
        input count, reached, exceeded, gate_ok, out_level);
    modport cnt (input mode, target,
        output count, reached, exceeded, gate_ok, out_level);
endinterface

// ### qhc_counter.sv
// one counter channel: edge detect, enable, compare
`timescale 1ns/1ps
module qhc_counter (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic cnt_pin_in,
    input wire logic gate_pin_in,
    qhc_cfg_if.cnt cfg
);
    typedef struct packed {
        logic [1:0] pin_sync; // count pin synchroniser
        logic [1:0] gate_sync; // gate pin synchroniser
        logic pin_prev; // last synced count level
        logic [15:0] count; // live count
        logic reached; // at target
        logic exceeded; // past target
        logic out_level; // output pin
    } qhc_cnt_state_t;
    qhc_cnt_state_t st_reg, st_next;
    logic edge_hit;
    logic enabled;
    // --------------------------------------------------------
    // next state
    // --------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pin_sync = {st_reg.pin_sync[0], cnt_pin_in};
        st_next.gate_sync = {st_reg.gate_sync[0], gate_pin_in};
        st_next.pin_prev = st_reg.pin_sync[1];
        // edge choice
        edge_hit = cfg.mode[qhc_pkg::MD_FALL] ?
            (st_reg.pin_prev & ~st_reg.pin_sync[1]) :
            (~st_reg.pin_prev & st_reg.pin_sync[1]);
        // enable polarity
        enabled = (st_reg.gate_sync[1] ==
            cfg.mode[qhc_pkg::MD_EN_HIGH]);
        if (edge_hit && enabled) begin
            // direction
            st_next.count = cfg.mode[qhc_pkg::MD_UP] ?
                st_reg.count + 16'h0001 : st_reg.count - 16'h0001;
        end
        st_next.reached = (st_reg.count == cfg.target);
        st_next.exceeded = cfg.mode[qhc_pkg::MD_UP] ?
            (st_reg.count > cfg.target) : (st_reg.count < cfg.target);
        // output polarity
        st_next.out_level = st_reg.reached ^
            cfg.mode[qhc_pkg::MD_OUT_LOW];
    end
    // --------------------------------------------------------
    // state register
    // --------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign cfg.count = st_reg.count;
    assign cfg.reached = st_reg.reached;
    assign cfg.exceeded = st_reg.exceeded;
    // status shows the synced gate level of channels 1 to 3, whatever the enable polarity
    assign cfg.gate_ok = st_reg.gate_sync[1];
    assign cfg.out_level = st_reg.out_level;
    // counter moves only on a qualified edge
    a_count_step: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !(edge_hit && enabled) |=> $stable(st_reg.count))
        else $error("count moved without a qualified edge");
endmodule

// ### quad_hsc_regs.sv
// four-channel counter register block with error checking
`timescale 1ns/1ps
module quad_hsc_regs #(
    parameter int LINK_TIMEOUT = qhc_pkg::LINK_TIMEOUT_CYC,
    parameter logic [15:0] TARGET_MAX = 16'hFFFE
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_idx_in,
    input wire logic [15:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [3:0] rd_idx_in,
    input wire logic [3:0] cnt_pin_in,
    input wire logic [3:0] gate_pin_in,
    input wire logic link_alive_in,
    input wire logic [7:0] card_id_in,
    input wire logic repeat_req_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic [3:0] cnt_out
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // watchdog counter is 16 bits wide
    if (LINK_TIMEOUT < 1 || LINK_TIMEOUT > 65535) begin : g_bad_timeout
        $error("link timeout out of range");
    end
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][15:0] mode; // mode words, index = channel-1
        logic [3:0][15:0] target; // target counts
        logic [3:0][15:0] err; // error codes
        logic [1:0] alive_sync; // link heartbeat synchroniser
        logic alive_prev; // last heartbeat
        logic [15:0] wdog; // cycles since heartbeat
        logic comms_lost; // link lost flag
        logic [7:0] id_s1; // id first stage
        logic [7:0] id_s2; // id second stage
        logic [1:0] rep_sync; // repeat request sync
        logic [15:0] rd_data; // read data
        logic rd_valid; // read strobe
        logic [3:0] cnt_o; // counter output pins
    } qhc_top_state_t;
    qhc_top_state_t st_reg, st_next;
    logic [3:0][15:0] live_count;
    logic [3:0] reached, exceeded, gate_ok, out_lv;
    logic [15:0] status_word;
    logic [1:0] wr_ch;
    logic [15:0] chk_code;
    // ------------------------------------------------------------
    // channel instances
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < qhc_pkg::NUM_CH; g++) begin : gen_ch
            qhc_cfg_if cfg_i ();
            assign cfg_i.mode = st_reg.mode[g];
            assign cfg_i.target = st_reg.target[g];
            assign live_count[g] = cfg_i.count;
            assign reached[g] = cfg_i.reached;
            assign exceeded[g] = cfg_i.exceeded;
            assign gate_ok[g] = cfg_i.gate_ok;
            assign out_lv[g] = cfg_i.out_level;
            qhc_counter qhc_counter_i (
                .clk_sys_in(clk_sys_in),
                .rst_b_in(rst_b_in),
                .cnt_pin_in(cnt_pin_in[g]),
                .gate_pin_in(gate_pin_in[g]),
                .cfg(cfg_i.cnt)
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // configuration check for one channel write
    // ------------------------------------------------------------
    function automatic logic [15:0] check_mode(
        input logic [1:0] ch,
        input logic [15:0] m,
        input logic [15:0] old_m,
        input logic rep,
        input logic diff_pair
    );
        logic fast;
        logic diff;
        fast = m[qhc_pkg::MD_FAST];
        diff = m[qhc_pkg::MD_DIFF];
        if (ch == 2'd0 && diff && fast) begin
            check_mode = qhc_pkg::ERR_DIFF_FAST;
        end else if ((ch == 2'd0 || ch == 2'd2) && diff && rep) begin
            check_mode = qhc_pkg::ERR_DIFF_REP;
        end else if (ch != 2'd0 && fast) begin
            check_mode = qhc_pkg::ERR_FAST_CH;
        end else if ((ch == 2'd1 || ch == 2'd3) && diff) begin
            check_mode = qhc_pkg::ERR_DIFF_CH;
        end else if ((ch == 2'd1 || ch == 2'd3) && diff_pair &&
                     (m[6:1] != old_m[6:1])) begin
            check_mode = qhc_pkg::ERR_MODE_CHG;
        end else begin
            check_mode = qhc_pkg::ERR_NONE;
        end
    endfunction
    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    always_comb begin
        status_word = 16'h0000;
        status_word[qhc_pkg::ST_COMMS_LOSS] = st_reg.comms_lost;
        status_word[qhc_pkg::ST_UNHEALTHY] =
            (st_reg.id_s2 != qhc_pkg::CARD_ID);
        // bits 13, 12 and 3 stay zero
        status_word[13:12] = 2'b00;
        status_word[3] = 1'b0;
        for (int i = 0; i < qhc_pkg::NUM_CH; i++) begin
            status_word[qhc_pkg::ST_EXCEED_LO + i] = exceeded[i];
            status_word[qhc_pkg::ST_REACH_LO + i] = reached[i];
        end
        status_word[2:0] = gate_ok[2:0];
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        wr_ch = wr_idx_in[2:1];
        chk_code = qhc_pkg::ERR_NONE;
        // synchronisers
        st_next.alive_sync = {st_reg.alive_sync[0], link_alive_in};
        st_next.alive_prev = st_reg.alive_sync[1];
        st_next.id_s1 = card_id_in;
        st_next.id_s2 = st_reg.id_s1;
        st_next.rep_sync = {st_reg.rep_sync[0], repeat_req_in};
        // link watchdog: any heartbeat edge restarts it
        if (st_reg.alive_sync[1] != st_reg.alive_prev) begin
            st_next.wdog = 16'h0000;
            st_next.comms_lost = 1'b0;
        end else if (st_reg.wdog >= 16'(LINK_TIMEOUT - 1)) begin
            st_next.comms_lost = 1'b1;
        end else begin
            st_next.wdog = st_reg.wdog + 16'h0001;
        end
        // master writes: even index mode, odd index target
        if (wr_en_in) begin
            if (!wr_idx_in[0]) begin
                // bits 15..7 and bit 0 are not stored
                st_next.mode[wr_ch] = wr_data_in & 16'h007E;
                chk_code = check_mode(wr_ch, wr_data_in,
                    st_reg.mode[wr_ch], st_reg.rep_sync[1],
                    st_reg.mode[0][qhc_pkg::MD_DIFF] |
                    st_reg.mode[2][qhc_pkg::MD_DIFF]);
                st_next.err[wr_ch] = chk_code;
                if (chk_code != qhc_pkg::ERR_NONE) begin
                    st_next.mode[wr_ch] = st_reg.mode[wr_ch];
                end
            end else if (wr_data_in > TARGET_MAX) begin
                st_next.err[wr_ch] = qhc_pkg::ERR_TARGET;
            end else begin
                st_next.target[wr_ch] = wr_data_in;
                st_next.err[wr_ch] = qhc_pkg::ERR_NONE;
            end
        end
        // read mux, channel 4 first
        st_next.rd_valid = rd_en_in;
        if (rd_en_in) begin
            if (rd_idx_in == qhc_pkg::IN_STATUS) begin
                st_next.rd_data = status_word;
            end else if (rd_idx_in < qhc_pkg::IN_CNT_BASE) begin
                st_next.rd_data =
                    st_reg.err[2'(4'd4 - rd_idx_in)];
            end else if (rd_idx_in <= qhc_pkg::IN_LAST) begin
                st_next.rd_data =
                    live_count[2'(4'd8 - rd_idx_in)];
            end else begin
                st_next.rd_data = 16'h0000;
            end
        end
        st_next.cnt_o = out_lv;
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
            st_reg.mode <= {4{qhc_pkg::MODE_RESET}};
            st_reg.target <= {4{qhc_pkg::TARGET_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end
    assign rd_data_out = st_reg.rd_data;
    assign rd_valid_out = st_reg.rd_valid;
    assign cnt_out = st_reg.cnt_o;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reserved status bits read low
    a_unused_bits: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        rd_valid_out && $past(rd_idx_in) == 4'h0
        |-> rd_data_out[13:12] == 2'b00 && !rd_data_out[3])
        else $error("reserved status bits set");
    // fast mode off channel 1; differential left out, with repeat on channel 3 it ranks higher
    a_fast_reject: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_en_in && !wr_idx_in[0] && wr_idx_in[2:1] != 2'd0 &&
        wr_data_in[2] && !wr_data_in[1]
        |=> st_reg.err[$past(wr_idx_in[2:1])] == qhc_pkg::ERR_FAST_CH)
        else $error("fast mode not refused");
    // differential on channel 2 or 4
    a_diff_reject: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_en_in && !wr_idx_in[0] && wr_idx_in[1] &&
        wr_data_in[1] && !wr_data_in[2]
        |=> st_reg.err[$past(wr_idx_in[2:1])] == qhc_pkg::ERR_DIFF_CH)
        else $error("differential not refused");
    // out-of-range target keeps the old one
    a_target_bad: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_en_in && wr_idx_in[0] && wr_data_in > TARGET_MAX
        |=> st_reg.err[$past(wr_idx_in[2:1])] == qhc_pkg::ERR_TARGET &&
            $stable(st_reg.target))
        else $error("bad target accepted");
    // loss flag only after the full quiet span
    a_comms_flag: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        st_reg.comms_lost |-> st_reg.wdog >= 16'(LINK_TIMEOUT - 1))
        else $error("comms loss flagged early");
    // unused mode bits of channel 1 never stored
    a_mode_mask: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        st_reg.mode[0][15:7] == 9'h000 && !st_reg.mode[0][0])
        else $error("unused mode bits stored");
    // read strobe answered one cycle later, for one cycle
    a_read_lat: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        rd_en_in |=> rd_valid_out ##1 (rd_valid_out == $past(rd_en_in)))
        else $error("read strobe timing wrong");
    // wrong id through both sync stages flags the card
    a_id_health: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (card_id_in != qhc_pkg::CARD_ID) [*3] |-> status_word[14])
        else $error("bad card id not flagged");
endmodule

// ### qhc_master.sv
// remote master model: writes output words and reads input words
`timescale 1ns/1ps
module qhc_master (
    input wire logic clk_sys_in,
    output logic wr_en_out,
    output logic [2:0] wr_idx_out,
    output logic [15:0] wr_data_out,
    output logic rd_en_out,
    output logic [3:0] rd_idx_out,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in
);
    // ------------------------------------------------------------
    // idle levels at time zero
    // ------------------------------------------------------------
    initial begin
        wr_en_out = 1'b0;
        wr_idx_out = 3'h0;
        wr_data_out = 16'h0000;
        rd_en_out = 1'b0;
        rd_idx_out = 4'h0;
    end
    // one output word, held until the edge that takes it
    task automatic write_word(input logic [2:0] idx, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr_idx_out <= idx;
        // mode words keep the upper unused bits clear
        wr_data_out <= idx[0] ? d : {9'h000, d[6:0]};
        wr_en_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_en_out <= 1'b0;
        // released bus shows no stale value
        wr_data_out <= ~d;
    endtask
    // one input word; answer taken at the edge after the taking edge
    task automatic read_word(input logic [3:0] idx, output logic [15:0] d,
        output logic v);
        @(posedge clk_sys_in);
        rd_idx_out <= idx;
        rd_en_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_en_out <= 1'b0;
        rd_idx_out <= ~idx;
        @(posedge clk_sys_in);
        d = rd_data_in;
        v = rd_valid_in;
    endtask
endmodule

// ### quad_hsc_regs_tb.sv
// self-checking testbench for the four-channel counter registers
`timescale 1ns/1ps
module quad_hsc_regs_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys, rst_b, wr_en, rd_en, rd_valid, link_alive, link_run;
    logic repeat_req;
    logic [2:0] wr_idx;
    logic [3:0] rd_idx, cnt_pin, gate_pin, cnt_out;
    logic [15:0] wr_data, rd_data;
    logic [7:0] card_id;
    int fail_count, num_checks;
    // short watchdog so link loss shows quickly
    quad_hsc_regs #(.LINK_TIMEOUT(8)) quad_hsc_regs_i (
        .clk_sys_in(clk_sys), .rst_b_in(rst_b), .wr_en_in(wr_en),
        .wr_idx_in(wr_idx), .wr_data_in(wr_data), .rd_en_in(rd_en),
        .rd_idx_in(rd_idx), .cnt_pin_in(cnt_pin), .gate_pin_in(gate_pin),
        .link_alive_in(link_alive), .card_id_in(card_id),
        .repeat_req_in(repeat_req), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .cnt_out(cnt_out));
    qhc_master qhc_master_i (
        .clk_sys_in(clk_sys), .wr_en_out(wr_en), .wr_idx_out(wr_idx),
        .wr_data_out(wr_data), .rd_en_out(rd_en), .rd_idx_out(rd_idx),
        .rd_data_in(rd_data), .rd_valid_in(rd_valid));
    // ------------------------------------------------------------
    // clock, heartbeat and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (link_run) link_alive <= ~link_alive;
    initial begin
        #500_000;
        fail_count++;
        conclude();
    end
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read one word, check the strobe and the masked value
    task automatic rd_chk(input logic [3:0] idx, input logic [15:0] mask,
        input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        qhc_master_i.read_word(idx, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d & mask, exp);
    endtask
    // set the repeat request, write a word, read back one error code
    task automatic err_step(input logic [2:0] w, input logic [15:0] d,
        input logic rep, input logic [3:0] r, input logic [15:0] code);
        @(posedge clk_sys);
        repeat_req <= rep;
        wait_cyc(3);
        qhc_master_i.write_word(w, d);
        rd_chk(r, 16'hFFFF, code);
    endtask
    // one full pulse on channel 1 count pin
    task automatic pulse1();
        cnt_pin[0] <= 1'b1;
        wait_cyc(5);
        cnt_pin[0] <= 1'b0;
        wait_cyc(5);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(4'h0, 16'hFFF8, 16'h00F0);
        for (int i = 1; i < 9; i++) begin
            rd_chk(4'(i), 16'hFFFF, 16'h0000);
        end
        rd_chk(4'h9, 16'hFFFF, 16'h0000);
    endtask
    task automatic t_errors();
        err_step(3'h0, 16'h0046, 1'b0, 4'h4, qhc_pkg::ERR_DIFF_FAST);
        err_step(3'h2, 16'h0044, 1'b0, 4'h3, qhc_pkg::ERR_FAST_CH);
        err_step(3'h4, 16'h0044, 1'b0, 4'h2, qhc_pkg::ERR_FAST_CH);
        err_step(3'h6, 16'h0044, 1'b0, 4'h1, qhc_pkg::ERR_FAST_CH);
        err_step(3'h2, 16'h0042, 1'b0, 4'h3, qhc_pkg::ERR_DIFF_CH);
        err_step(3'h6, 16'h0042, 1'b0, 4'h1, qhc_pkg::ERR_DIFF_CH);
        err_step(3'h1, 16'hFFFF, 1'b0, 4'h4, qhc_pkg::ERR_TARGET);
        err_step(3'h0, 16'h0042, 1'b1, 4'h4, qhc_pkg::ERR_DIFF_REP);
        err_step(3'h4, 16'h0042, 1'b1, 4'h2, qhc_pkg::ERR_DIFF_REP);
        err_step(3'h0, 16'h0042, 1'b0, 4'h4, qhc_pkg::ERR_NONE);
        err_step(3'h2, 16'h0050, 1'b0, 4'h3, qhc_pkg::ERR_MODE_CHG);
        err_step(3'h6, 16'h0050, 1'b0, 4'h1, qhc_pkg::ERR_MODE_CHG);
        err_step(3'h0, 16'h0041, 1'b0, 4'h4, qhc_pkg::ERR_NONE);
        err_step(3'h2, 16'h0040, 1'b0, 4'h3, qhc_pkg::ERR_NONE);
    endtask
    task automatic t_count();
        gate_pin <= 4'h1;
        qhc_master_i.write_word(3'h0, 16'h0050);
        qhc_master_i.write_word(3'h1, 16'h0003);
        repeat (3) pulse1();
        rd_chk(4'h0, 16'hFFF9, 16'h00F1);
        rd_chk(4'h8, 16'hFFFF, 16'h0003);
        rd_chk(4'h5, 16'hFFFF, 16'h0000);
        chk({12'h000, cnt_out}, 16'h000F);
        qhc_master_i.write_word(3'h0, 16'h0070);
        wait_cyc(3);
        chk({12'h000, cnt_out}, 16'h000E);
        qhc_master_i.write_word(3'h0, 16'h0058);
        cnt_pin[0] <= 1'b1;
        wait_cyc(5);
        rd_chk(4'h8, 16'hFFFF, 16'h0003);
        cnt_pin[0] <= 1'b0;
        wait_cyc(5);
        rd_chk(4'h8, 16'hFFFF, 16'h0004);
        rd_chk(4'h0, 16'hFFF9, 16'h01E1);
        gate_pin <= 4'h0;
        pulse1();
        rd_chk(4'h8, 16'hFFFF, 16'h0004);
        // down counting on rising edges, fast option kept on channel 1
        gate_pin <= 4'h1;
        qhc_master_i.write_word(3'h0, 16'h0014);
        repeat (2) pulse1();
        rd_chk(4'h4, 16'hFFFF, qhc_pkg::ERR_NONE);
        rd_chk(4'h8, 16'hFFFF, 16'h0002);
        rd_chk(4'h0, 16'hFFF9, 16'h01E1);
    endtask
    task automatic t_link();
        link_run <= 1'b0;
        wait_cyc(12);
        rd_chk(4'h0, 16'h8000, 16'h8000);
        link_run <= 1'b1;
        wait_cyc(4);
        rd_chk(4'h0, 16'h8000, 16'h0000);
        card_id <= ~qhc_pkg::CARD_ID;
        wait_cyc(4);
        rd_chk(4'h0, 16'h4000, 16'h4000);
        card_id <= qhc_pkg::CARD_ID;
        wait_cyc(4);
        rd_chk(4'h0, 16'h4000, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        link_alive = 1'b0;
        link_run = 1'b1;
        repeat_req = 1'b0;
        cnt_pin = 4'h0;
        gate_pin = 4'h0;
        card_id = qhc_pkg::CARD_ID;
        fail_count = 0;
        num_checks = 0;
        wait_cyc(2);
        rst_b <= 1'b1;
        wait_cyc(4);
        t_reset();
        t_errors();
        t_count();
        t_link();
        conclude();
    end
endmodule
